// File: logic/prog_seq.sv
// Program sequencer: counter, return stack, data pointer, RAM, ROM and protect
`timescale 1ns/10ps
`include "prog_seq_map.svh"

module prog_seq
    import prog_seq_pkg::*;
#(
    parameter int PC_W = 12,
    parameter int DEPTH = 8,
    parameter int PORT_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor state to save on interrupt entry, and back-up exit
    input wire logic carry_in,
    input wire logic [3:0] acc_in,
    input wire logic [3:0] breg_in,
    input wire logic backup_exit,
    // Sequencer outputs
    output logic [PC_W-1:0] fetch_addr,
    output logic skip_flag,
    output logic [PORT_W-1:0] port_bits
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [PC_W-1:0] pc_q, pc_d;           // Program counter
    logic [2:0] sp_q, sp_d;                // Return level pointer
    logic [PC_W-1:0] slot_q [DEPTH];       // Return slots
    logic skip_q, skip_d;                  // Skip flag
    logic z_q;                             // Group select
    logic [3:0] x_q, y_q;                  // File and digit select
    logic [3:0] ram_q [256];               // Data memory
    logic [9:0] rom_q [1 << PC_W];         // Program memory
    logic [PC_W-1:0] rom_addr_q;           // Programmer address
    logic protect_q;                       // Read protect latch
    logic [7:0] table_q;                   // Last lookup data
    logic [13:0] save_q;                   // Saved skip, carry, acc, b and file select
    logic [4:0] save_y_q;                  // Saved group and digit select
    logic [PORT_W-1:0] port_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    wire access = psel & penable;
    wire fire = access & pready_q;       // Transfer ends this edge
    wire wr = fire & pwrite;
    wire hit_cmd = paddr == `OFS_CMD;
    wire hit_status = paddr == `OFS_STATUS;
    wire hit_ptr = paddr == `OFS_POINTER;
    wire hit_ram = paddr == `OFS_RAM_DATA;
    wire hit_rbit = paddr == `OFS_RAM_BIT;
    wire hit_pbit = paddr == `OFS_PORT_BIT;
    wire hit_table = paddr == `OFS_TABLE;
    wire hit_raddr = paddr == `OFS_ROM_ADDR;
    wire hit_rdata = paddr == `OFS_ROM_DATA;
    wire hit_prot = paddr == `OFS_PROTECT;
    wire hit_save = paddr == `OFS_SAVE;
    wire mapped = hit_cmd | hit_status | hit_ptr | hit_ram | hit_rbit | hit_pbit
        | hit_table | hit_raddr | hit_rdata | hit_prot | hit_save;
    // Programmer access to ROM while protected is refused
    wire rom_refused = hit_rdata & protect_q;
    wire bad = ~mapped | rom_refused;

    ////////////////////////////////////////////////////////////////////////
    // Command decode
    wire [8:0] op_raw = pwdata[8:0];
    wire cmd_go = wr & hit_cmd;
    wire [PC_W-1:0] tgt = pwdata[`CMD_TGT_LSB +: PC_W];
    // One or two word instruction length
    wire [PC_W-1:0] len = pwdata[`CMD_LEN_BIT] ? PC_W'(2) : PC_W'(1);
    wire [PC_W-1:0] next_pc = pc_q + len;
    wire [2:0] sp_up = sp_q + 3'h1;
    wire [2:0] sp_dn = sp_q - 3'h1;
    // Page field on top, word field bits 6:0
    wire [PC_W-8:0] page_field = pc_q[PC_W-1:7];
    wire [6:0] word_field = pc_q[6:0];
    wire [PC_W-1:0] vec_addr = `VEC_BASE | {{(PC_W-7){1'b0}}, tgt[6:0]};
    wire [PC_W-1:0] common_addr = {(PC_W-7)'(`COMMON_PAGE), tgt[6:0]};
    wire [7:0] ram_idx = {x_q, y_q};
    wire [3:0] ram_word = ram_q[ram_idx];
    wire [3:0] ram_bit_mask = 4'h1 << pwdata[1:0];
    wire [1:0] bit_op = pwdata[3:2];
    wire [PORT_W-1:0] port_mask = PORT_W'(1) << y_q;
    wire rbit_zero = (ram_word & ram_bit_mask) == 4'h0;
    wire pbit_zero = (port_q & port_mask) == '0;
    wire [9:0] rom_word = rom_q[tgt];

    ////////////////////////////////////////////////////////////////////////
    // Next program counter, pointer and skip
    always_comb begin
        pc_d = pc_q;
        sp_d = sp_q;
        skip_d = skip_q;
        if (cmd_go && op_raw == OP_INTR) begin // Taken even while a skip is pending
            pc_d = vec_addr;
            sp_d = sp_up;
            skip_d = 1'b0;
        end else if (cmd_go && skip_q) begin
            // Skipped instruction runs as a no-op of its own length
            pc_d = next_pc;
            skip_d = 1'b0;
        end else if (cmd_go) begin
            case (op_raw)
                OP_STEP: pc_d = next_pc;
                OP_BRANCH: pc_d = tgt;
                OP_CALL: begin
                    pc_d = tgt;
                    sp_d = sp_up;
                end
                OP_COMMON: begin
                    pc_d = common_addr;
                    sp_d = sp_up;
                end
                OP_RETURN: begin
                    pc_d = slot_q[sp_q];
                    sp_d = sp_dn;
                end
                OP_RTI: begin
                    pc_d = slot_q[sp_q];
                    sp_d = sp_dn;
                    skip_d = save_q[13];
                end
                // Lookup borrows a slot and hands it back in the same step
                OP_TABLE: pc_d = pc_q + PC_W'(1);
                OP_SKIP: begin
                    pc_d = next_pc;
                    skip_d = 1'b1;
                end
                default: pc_d = pc_q;
            endcase
        end else if (wr && hit_rbit && bit_op == `BITOP_TEST) begin
            skip_d = rbit_zero | skip_q;
        end else if (wr && hit_pbit && bit_op == `BITOP_TEST) begin
            skip_d = pbit_zero | skip_q;
        end
    end
    wire push = cmd_go & ((op_raw == OP_INTR) | (~skip_q & (op_raw == OP_CALL
        || op_raw == OP_COMMON || op_raw == OP_TABLE)));
    // Return address: the instruction after the current one, or the current one for an interrupt
    wire [PC_W-1:0] ret_addr = (op_raw == OP_INTR) ? pc_q : next_pc;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= '0;
            sp_q <= `SP_RESET;
            skip_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            sp_q <= backup_exit ? `SP_RESET : sp_d;
            skip_q <= skip_d;
        end
    end

    // Return slots; a full stack silently overwrites slot 0
    always_ff @(posedge pclk) begin
        if (push) begin
            slot_q[sp_up] <= ret_addr;
        end
    end

    // Interrupt save stage; calls and lookups leave it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            save_q <= '0;
            save_y_q <= '0;
        end else if (cmd_go && op_raw == OP_INTR) begin
            save_q <= {skip_q, carry_in, acc_in, breg_in, x_q};
            save_y_q <= {z_q, y_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data pointer; group select is not cleared, software must load it
    always_ff @(posedge pclk) begin
        if (wr && hit_ptr) begin
            z_q <= pwdata[8];
            x_q <= pwdata[7:4];
            y_q <= pwdata[3:0];
        end else if (cmd_go && !skip_q && op_raw == OP_RTI) begin
            z_q <= save_y_q[4];
            x_q <= save_q[3:0];
            y_q <= save_y_q[3:0];
        end
    end

    // Data memory: nibble writes and single bit set or clear
    always_ff @(posedge pclk) begin
        if (wr && hit_ram) begin
            ram_q[ram_idx] <= pwdata[3:0];
        end else if (wr && hit_rbit && bit_op == `BITOP_SET) begin
            ram_q[ram_idx] <= ram_word | ram_bit_mask;
        end else if (wr && hit_rbit && bit_op == `BITOP_CLEAR) begin
            ram_q[ram_idx] <= ram_word & ~ram_bit_mask;
        end
    end

    // Program memory, written by the programmer unless protected
    always_ff @(posedge pclk) begin
        if (wr && hit_rdata && !protect_q) begin
            rom_q[rom_addr_q] <= pwdata[9:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port bits, programmer address, protect, lookup data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_q <= '0;
            rom_addr_q <= '0;
            protect_q <= 1'b0;
            table_q <= '0;
        end else begin
            if (wr && hit_pbit && bit_op == `BITOP_SET) begin
                port_q <= port_q | port_mask;
            end else if (wr && hit_pbit && bit_op == `BITOP_CLEAR) begin
                port_q <= port_q & ~port_mask;
            end
            if (wr && hit_raddr) begin
                rom_addr_q <= pwdata[PC_W-1:0];
            end
            // Protect can only be set; reset is the sole way back
            if (wr && hit_prot && pwdata[0]) begin
                protect_q <= 1'b1;
            end
            if (cmd_go && !skip_q && op_raw == OP_TABLE) begin
                table_q <= rom_word[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; refused ROM reads return zero
    wire [31:0] rd_val =
        hit_status ? {10'h0, save_q[13], skip_q, 1'b0, sp_q, 4'h0,
            (PC_W)'(pc_q)} :
        hit_ptr ? {23'h0, z_q, x_q, y_q} :
        hit_ram ? {28'h0, ram_word} :
        hit_pbit ? {{(32-PORT_W){1'b0}}, port_q} :
        hit_table ? {24'h0, table_q} :
        hit_raddr ? {{(32-PC_W){1'b0}}, rom_addr_q} :
        (hit_rdata && !protect_q) ? {22'h0, rom_q[rom_addr_q]} :
        hit_prot ? {31'h0, protect_q} :
        hit_save ? {13'h0, save_y_q, save_q} :
        32'h0;

    // One wait state, then the answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & bad;
            prdata_q <= (access && !pready_q && !pwrite) ? rd_val : prdata_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign fetch_addr = pc_q;
    assign skip_flag = skip_q;
    assign port_bits = port_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    wire plain = cmd_go & ~skip_q;
    a_sp_after_backup: assert property (@(posedge pclk) disable iff (!presetn)
        backup_exit |=> sp_q == 3'h7) else $error("pointer not 7 after back-up");
    a_call_push_slot: assert property (@(posedge pclk) disable iff (!presetn)
        (plain && op_raw == OP_CALL && !backup_exit) |=> sp_q == $past(sp_q) + 3'h1
        && slot_q[sp_q] == $past(next_pc)) else $error("call push wrong");
    a_call_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (plain && op_raw == OP_CALL && sp_q == 3'h7 && !backup_exit) |=> sp_q == 3'h0)
        else $error("pointer did not wrap");
    a_step_advance: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_go && op_raw == OP_STEP) |=> pc_q == $past(pc_q) + $past(len))
        else $error("counter step wrong");
    a_page_carry: assert property (@(posedge pclk) disable iff (!presetn)
        (plain && op_raw == OP_STEP && word_field == 7'h7f && !pwdata[`CMD_LEN_BIT])
        |=> pc_q[6:0] == 7'h0 && pc_q[PC_W-1:7] == $past(page_field) + 1'b1)
        else $error("page rollover wrong");
    a_branch_load: assert property (@(posedge pclk) disable iff (!presetn)
        (plain && op_raw == OP_BRANCH) |=> pc_q == $past(tgt))
        else $error("branch target not loaded");
    a_vector_range: assert property (@(posedge pclk) disable iff (!presetn)
        (plain && op_raw == OP_INTR) |=> pc_q >= `VEC_BASE && pc_q <= `VEC_LAST)
        else $error("vector outside page 1");
    a_int_skip_save: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_go && op_raw == OP_INTR) |=> save_q[13] == $past(skip_q))
        else $error("skip not saved");
    a_rti_skip_restore: assert property (@(posedge pclk) disable iff (!presetn)
        (plain && op_raw == OP_RTI) |=> skip_q == $past(save_q[13])) else $error("skip lost");
    a_return_pop: assert property (@(posedge pclk) disable iff (!presetn)
        (plain && op_raw == OP_RETURN && !backup_exit) |=> sp_q == $past(sp_q) - 3'h1
        && pc_q == $past(slot_q[sp_q])) else $error("return pop wrong");
    a_skip_nop: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_go && skip_q && op_raw != OP_INTR && !backup_exit)
        |=> !skip_q && sp_q == $past(sp_q)) else $error("skipped op had effect");
    a_protect_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pready_q && hit_rdata && protect_q) |=> pslverr_q && pready_q)
        else $error("protected access not refused");
endmodule

// File: logic/prog_seq_map.svh
// Register offsets, field positions, reset values and operation codes of the sequencer
`ifndef PROG_SEQ_MAP_SVH
`define PROG_SEQ_MAP_SVH
`define OFS_CMD        12'h000
`define OFS_STATUS     12'h004
`define OFS_POINTER    12'h008
`define OFS_RAM_DATA   12'h00c
`define OFS_RAM_BIT    12'h010
`define OFS_PORT_BIT   12'h014
`define OFS_TABLE      12'h018
`define OFS_ROM_ADDR   12'h01c
`define OFS_ROM_DATA   12'h020
`define OFS_PROTECT    12'h024
`define OFS_SAVE       12'h028
`define CMD_LEN_BIT    12
`define CMD_TGT_LSB    16
`define SP_RESET       3'h7
`define VEC_BASE       12'h080
`define VEC_LAST       12'h0ff
`define COMMON_PAGE    5'h02
`define BITOP_SET      2'h1
`define BITOP_CLEAR    2'h2
`define BITOP_TEST     2'h3
`endif

// File: logic/prog_seq_pkg.sv
// Types shared by the sequencer core
package prog_seq_pkg;
    // Sequencer operations, one-hot
    typedef enum logic [8:0] {
        OP_STEP   = 9'h001,
        OP_BRANCH = 9'h002,
        OP_CALL   = 9'h004,
        OP_COMMON = 9'h008,
        OP_RETURN = 9'h010,
        OP_INTR   = 9'h020,
        OP_RTI    = 9'h040,
        OP_TABLE  = 9'h080,
        OP_SKIP   = 9'h100
    } seq_op_t;
endpackage

// File: testbench/testbench.sv
// Self-checking bench for the program sequencer, driven over APB
`timescale 1ns/10ps
`include "prog_seq_map.svh"
module testbench;
    import prog_seq_pkg::*;
    // One queued answer: data, compare mask, error response
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} exp_t;
    ////////////////////////////////////////////////////////////////////////
    // Clock, reset and APB
    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, carry_in, backup_exit;
    // CPU state seen on interrupt entry
    logic [3:0] acc_in, breg_in;
    // Sequencer outputs
    logic [11:0] fetch_addr;
    logic skip_flag;
    logic [15:0] port_bits;
    // Scoreboard state
    exp_t expq[$];
    exp_t e;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed;
    logic [9:0] rv;
    logic [3:0] nib [4];
    logic [3:0] dg [4];

    prog_seq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .carry_in(carry_in), .acc_in(acc_in), .breg_in(breg_in),
        .backup_exit(backup_exit), .fetch_addr(fetch_addr), .skip_flag(skip_flag),
        .port_bits(port_bits));

    ////////////////////////////////////////////////////////////////////////
    // 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Compare one value, count it, report a mismatch
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        comparisons++;
        if (seen !== want) begin
            miscompares++;
            $display("[ERR] %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    // Verdict and end of run
    task automatic stop_test();
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One APB transfer; the expected answer is queued before the request leaves
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        input logic [31:0] d, input logic [31:0] m, input logic err);
        expq.push_back('{d, m, err});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Hold the request until ready is seen high at a rising edge
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic err = 1'b0);
        xfer(1'b1, a, wd, 32'h0, 32'h0, err);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
        input logic err = 1'b0);
        xfer(1'b0, a, 32'h0, d, m, err);
    endtask

    // Sequencer command with its target field
    task automatic cmd(input logic [8:0] op, input logic [11:0] tgt, input logic two = 1'b0);
        wr(`OFS_CMD, {4'h0, tgt, 3'h0, two, 3'h0, op});
    endtask

    // Status: counter, level pointer and skip flag
    task automatic st(input logic [11:0] pc, input logic [2:0] ptr, input logic sk);
        rd(`OFS_STATUS, {11'h0, sk, 1'b0, ptr, 4'h0, pc}, 32'h0017_0fff);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watcher: every completed transfer takes the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = expq.pop_front();
            check(prdata & e.m, e.d, "read data");
            check({31'h0, pslverr}, {31'h0, e.e}, "response");
        end
    end

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        seed = 16;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        carry_in = 1'b0;
        acc_in = 4'h0;
        breg_in = 4'h0;
        backup_exit = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        carry_in <= 1'($random(seed));
        acc_in <= 4'($random(seed));
        breg_in <= 4'($random(seed));
        st(12'h000, 3'h7, 1'b0);
        cmd(OP_STEP, 12'h0);
        st(12'h001, 3'h7, 1'b0);
        cmd(OP_STEP, 12'h0, 1'b1);
        st(12'h003, 3'h7, 1'b0);
        cmd(OP_BRANCH, 12'h07f);
        st(12'h07f, 3'h7, 1'b0);
        cmd(OP_STEP, 12'h0);
        st(12'h080, 3'h7, 1'b0);
        cmd(OP_CALL, 12'h200);
        st(12'h200, 3'h0, 1'b0);
        cmd(OP_RETURN, 12'h0);
        st(12'h081, 3'h7, 1'b0);
        cmd(OP_COMMON, 12'h005);
        st(12'h105, 3'h0, 1'b0);
        cmd(OP_RETURN, 12'h0);
        st(12'h082, 3'h7, 1'b0);
        // Fill all eight slots, then one call too many
        for (int i = 0; i < 8; i++) begin
            cmd(OP_CALL, 12'h300 + 12'(i));
        end
        st(12'h307, 3'h7, 1'b0);
        cmd(OP_CALL, 12'h3a0);
        st(12'h3a0, 3'h0, 1'b0);
        cmd(OP_RETURN, 12'h0);
        st(12'h308, 3'h7, 1'b0);
        cmd(OP_INTR, 12'h00c);
        st(12'h08c, 3'h0, 1'b0);
        rd(`OFS_SAVE, {18'h0, 1'b0, carry_in, acc_in, breg_in, 4'h0}, 32'h0000_3ff0);
        cmd(OP_RTI, 12'h0);
        st(12'h308, 3'h7, 1'b0);
        // A set skip turns the next command other than an interrupt into a plain step
        cmd(OP_SKIP, 12'h0);
        st(12'h309, 3'h7, 1'b1);
        @(negedge pclk);
        check({20'h0, fetch_addr}, 32'h309, "fetch address");
        check({31'h0, skip_flag}, 32'h1, "skip flag");
        // Interrupt with a skip pending; the flag rides through the save stage
        cmd(OP_INTR, 12'h004);
        st(12'h084, 3'h0, 1'b0);
        rd(`OFS_SAVE, {18'h0, 1'b1, carry_in, acc_in, breg_in, 4'h0}, 32'h0000_3ff0);
        cmd(OP_RTI, 12'h0);
        st(12'h309, 3'h7, 1'b1);
        cmd(OP_BRANCH, 12'h000);
        st(12'h30a, 3'h7, 1'b0);
        rv = 10'($random(seed));
        wr(`OFS_ROM_ADDR, 32'h123);
        wr(`OFS_ROM_DATA, {22'h0, rv});
        rd(`OFS_ROM_DATA, {22'h0, rv}, 32'h3ff);
        cmd(OP_TABLE, 12'h123);
        rd(`OFS_TABLE, {24'h0, rv[7:0]}, 32'hff);
        // Distinct files so no two nibbles alias
        for (int i = 0; i < 4; i++) begin
            nib[i] = 4'($random(seed));
            dg[i] = 4'($random(seed));
            wr(`OFS_POINTER, {24'h0, 4'(i * 5), dg[i]});
            wr(`OFS_RAM_DATA, {28'h0, nib[i]});
        end
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_POINTER, {24'h0, 4'(i * 5), dg[i]});
            rd(`OFS_RAM_DATA, {28'h0, nib[i]}, 32'hf);
        end
        wr(`OFS_RAM_BIT, {28'h0, `BITOP_SET, 2'h2});
        wr(`OFS_RAM_BIT, {28'h0, `BITOP_CLEAR, 2'h0});
        rd(`OFS_RAM_DATA, {28'h0, (nib[3] | 4'h4) & 4'he}, 32'hf);
        wr(`OFS_RAM_BIT, {28'h0, `BITOP_TEST, 2'h0});
        rd(`OFS_STATUS, 32'h0010_0000, 32'h0010_0000);
        cmd(OP_STEP, 12'h0);
        wr(`OFS_POINTER, 32'h05);
        wr(`OFS_PORT_BIT, {28'h0, `BITOP_SET, 2'h0});
        @(negedge pclk);
        check({16'h0, port_bits}, 32'h20, "port bits");
        wr(`OFS_PORT_BIT, {28'h0, `BITOP_CLEAR, 2'h0});
        rd(`OFS_PORT_BIT, 32'h0, 32'hffff);
        // A cleared port bit tests as zero and arms the skip
        wr(`OFS_PORT_BIT, {28'h0, `BITOP_TEST, 2'h0});
        rd(`OFS_STATUS, 32'h0010_0000, 32'h0010_0000);
        cmd(OP_STEP, 12'h0);
        // Refusals: unmapped place, then protected program memory
        rd(12'h030, 32'h0, 32'hffff_ffff, 1'b1);
        wr(`OFS_PROTECT, 32'h1);
        rd(`OFS_PROTECT, 32'h1, 32'h1);
        rd(`OFS_ROM_DATA, 32'h0, 32'hffff_ffff, 1'b1);
        wr(`OFS_ROM_DATA, 32'h3ff, 1'b1);
        // The refused write must leave the word in place
        cmd(OP_TABLE, 12'h123);
        rd(`OFS_TABLE, {24'h0, rv[7:0]}, 32'hff);
        cmd(OP_CALL, 12'h050);
        @(posedge pclk);
        backup_exit <= 1'b1;
        @(posedge pclk);
        backup_exit <= 1'b0;
        rd(`OFS_STATUS, 32'h0007_0000, 32'h0007_0000);
        repeat (3) @(posedge pclk);
        stop_test();
    end
endmodule
